// File: rssq_sequencer.sv
`timescale 1ns/10ps
// Combines reset sources into one device reset and runs the start-up sequence.
module rssq_sequencer
    import rssq_pkg::*;
#(
    parameter int unsigned PUT_COUNT = rssq_pkg::PUT_CYCLES,
    parameter int unsigned FILTER_LEN = rssq_pkg::GLITCH_FILTER_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cfg_lp_brownout_enable,
    input wire logic cfg_external_reset_pin_enable,
    input wire logic cfg_low_voltage_programming_enable,
    input wire logic cfg_stack_reset_enable,
    input wire logic cfg_power_up_timer_enable_n,
    input wire logic brownout_low,
    input wire logic lp_brownout_low,
    input wire logic external_reset_pin_in,
    input wire logic watchdog_overflow,
    input wire logic watchdog_window_violation,
    input wire logic reset_instruction,
    input wire logic stack_overflow,
    input wire logic stack_underflow,
    input wire logic programming_mode,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic device_reset_n,
    output logic run_enable,
    output logic external_reset_pin_out,
    output logic external_reset_pin_oe_n,
    output logic pin_pullup_en,
    output logic gpio_in
);
    localparam int unsigned CW = $clog2(PUT_COUNT + 1);

    logic pin_s1_q, pin_s2_q;
    logic bo_s1_q, bo_s2_q, lbo_s1_q, lbo_s2_q, pm_s1_q, pm_s2_q;
    logic pin_filt;
    logic pin_func_en;
    logic brownout_any;
    logic pin_hold;
    logic sync_src;
    logic src_hold;
    logic prog_q;
    logic prog_exit;
    logic [ST_W-1:0] status_q;
    logic sw_pullup_q;
    rssq_state_t state_q;
    logic [CW-1:0] put_cnt_q;
    logic [3:0] rel_cnt_q;
    logic run_q, rst_n_q, pu_q, gpio_q;
    logic [7:0] rdata_q;

    // Asynchronous level inputs pass two flip-flops before use.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            bo_s1_q <= 1'b0;
            bo_s2_q <= 1'b0;
            lbo_s1_q <= 1'b0;
            lbo_s2_q <= 1'b0;
            pm_s1_q <= 1'b0;
            pm_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= external_reset_pin_in;
            pin_s2_q <= pin_s1_q;
            bo_s1_q <= brownout_low;
            bo_s2_q <= bo_s1_q;
            lbo_s1_q <= lp_brownout_low;
            lbo_s2_q <= lbo_s1_q;
            pm_s1_q <= programming_mode;
            pm_s2_q <= pm_s1_q;
        end
    end

    rssq_glitch_filter #(
        .LEN(FILTER_LEN)
    ) u_pin_filter (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .din(pin_s2_q),
        .dout(pin_filt)
    );

    // Pin function enable and the combined hold conditions.
    assign pin_func_en = cfg_external_reset_pin_enable | cfg_low_voltage_programming_enable;
    assign brownout_any = bo_s2_q | (cfg_lp_brownout_enable & lbo_s2_q);
    assign pin_hold = pin_func_en & ~pin_filt;
    assign prog_exit = prog_q & ~pm_s2_q;
    // Synchronous sources restart the sequence but skip the timer.
    assign sync_src = watchdog_overflow | watchdog_window_violation | reset_instruction
        | (cfg_stack_reset_enable & (stack_overflow | stack_underflow));
    // Any active source pulls the device reset at once, without waiting a state step.
    assign src_hold = pin_hold | sync_src | brownout_any | pm_s2_q | prog_exit;

    // Remembers programming mode so its falling edge can be seen.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prog_q <= 1'b0;
        end else begin
            prog_q <= pm_s2_q;
        end
    end

    // Start-up sequence: hold, power-up timer, wait for pin, then run.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= RSSQ_HOLD;
            put_cnt_q <= '0;
            rel_cnt_q <= '0;
        end else if (brownout_any || pm_s2_q || prog_exit) begin
            state_q <= RSSQ_HOLD;
            put_cnt_q <= '0;
        end else begin
            case (state_q)
                RSSQ_HOLD: begin
                    put_cnt_q <= '0;
                    if (!cfg_power_up_timer_enable_n) begin
                        state_q <= RSSQ_TIMER;
                    end else begin
                        state_q <= RSSQ_PIN_WAIT;
                        rel_cnt_q <= '0;
                    end
                end
                RSSQ_TIMER: begin
                    // Timer ignores the pin level while it counts.
                    if (put_cnt_q == CW'(PUT_COUNT - 1)) begin
                        state_q <= RSSQ_PIN_WAIT;
                        rel_cnt_q <= '0;
                    end else begin
                        put_cnt_q <= put_cnt_q + 1'b1;
                    end
                end
                RSSQ_PIN_WAIT: begin
                    if (pin_hold) begin
                        rel_cnt_q <= '0;
                    end else if (rel_cnt_q == 4'(PIN_RELEASE_CYCLES - 1)) begin
                        state_q <= RSSQ_RUN;
                    end else begin
                        rel_cnt_q <= rel_cnt_q + 1'b1;
                    end
                end
                RSSQ_RUN: begin
                    if (pin_hold || sync_src) begin
                        state_q <= RSSQ_PIN_WAIT;
                        rel_cnt_q <= '0;
                    end
                end
                default: begin
                    state_q <= RSSQ_HOLD;
                end
            endcase
        end
    end

    // Cause flags; hardware events win over a software write in the same cycle.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            status_q <= STATUS_POR_VALUE;
        end else begin
            logic [ST_W-1:0] nxt;
            nxt = status_q;
            if (reg_wr && reg_addr == REG_STATUS) begin
                nxt = reg_wdata;
            end
            if (brownout_any) begin
                nxt[ST_BROWNOUT] = 1'b0;
            end
            if (prog_exit) begin
                nxt[ST_POWERON] = 1'b0;
            end
            if (reset_instruction) begin
                nxt[ST_RESET_INSTR] = 1'b0;
            end
            if (pin_hold && state_q == RSSQ_RUN) begin
                nxt[ST_PIN] = 1'b0;
            end
            if (watchdog_window_violation) begin
                nxt[ST_WINDOW_VIOL] = 1'b0;
            end
            if (stack_underflow) begin
                nxt[ST_STACK_UNDER] = 1'b1;
            end
            if (stack_overflow) begin
                nxt[ST_STACK_OVER] = 1'b1;
            end
            if (watchdog_overflow) begin
                nxt[ST_TIMEOUT] = 1'b0;
            end
            status_q <= nxt;
        end
    end

    // Software pull-up control used only when the pin is a plain input.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sw_pullup_q <= 1'b0;
        end else if (reg_wr && reg_addr == REG_PULLUP) begin
            sw_pullup_q <= reg_wdata[0];
        end
    end

    // Registered outputs.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            run_q <= 1'b0;
            rst_n_q <= 1'b0;
            pu_q <= 1'b1;
            gpio_q <= 1'b1;
        end else begin
            run_q <= (state_q == RSSQ_RUN) && !src_hold;
            rst_n_q <= (state_q == RSSQ_RUN) && !src_hold;
            pu_q <= pin_func_en | sw_pullup_q;
            gpio_q <= pin_func_en ? 1'b1 : pin_s2_q;
        end
    end

    // Register read data appears the cycle after the read strobe.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_STATUS: rdata_q <= status_q;
                REG_STATE: rdata_q <= {5'h00, pin_func_en, state_q};
                REG_PULLUP: rdata_q <= {7'h00, sw_pullup_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign device_reset_n = rst_n_q;
    assign run_enable = run_q;
    assign external_reset_pin_out = 1'b1;
    assign external_reset_pin_oe_n = 1'b1;
    assign pin_pullup_en = pu_q;
    assign gpio_in = gpio_q;
endmodule // rssq_sequencer

// File: rssq_pkg.sv
// Summary of operation
// - Enabled low-power brown-out detector holds reset while supply stays below threshold.
// - Both brown-out detectors update one shared brown-out cause flag.
// - A configuration bit enables the low-power detector; erased state disables it.
// - Reset pin is disabled only when pin enable and low-voltage programming are 0.
// - With pin function enabled, a low pin holds the device in reset.
// - With pin function enabled, the weak pull-up to supply is connected.
// - A glitch filter ignores short pulses on the reset pin.
// - No internal reset ever drives the reset pin low.
// - With pin function disabled, pin is a general input with software pull-up.
// - Watchdog overflow writes 0 to the timeout flag; window violation writes 0 to its flag.
// - Reset instruction fully resets the device and writes 0 to its cause flag.
// - Stack overflow or underflow sets its flag; resets only if enabled.
// - Leaving programming mode reruns the start-up sequence like a power-on reset and writes 0 to the power-on flag.
// - Power-up timer optionally holds off execution after power-on or brown-out reset.
// - Execution waits for power-up timer and reset pin release after such a reset.
// - Timer runs regardless of pin; late pin release starts execution 10 cycles later.
// - The power-up timer gives a nominal 64 ms hold-off.
// - The power-up timer is enabled when its configuration bit is cleared.
package rssq_pkg;
    // Clock rate and start-up timing.
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned PUT_MS = 64;
    localparam longint unsigned PUT_CYCLES_L = (longint'(PUT_MS) * CLK_HZ) / 1000;
    localparam int unsigned PUT_CYCLES = int'(PUT_CYCLES_L);
    localparam int unsigned PIN_RELEASE_CYCLES = 10;
    localparam int unsigned GLITCH_FILTER_CYCLES = 8;
    // Status flag bit positions.
    localparam int unsigned ST_W = 8;
    localparam int unsigned ST_BROWNOUT = 0;
    localparam int unsigned ST_POWERON = 1;
    localparam int unsigned ST_RESET_INSTR = 2;
    localparam int unsigned ST_PIN = 3;
    localparam int unsigned ST_WINDOW_VIOL = 4;
    localparam int unsigned ST_STACK_UNDER = 5;
    localparam int unsigned ST_STACK_OVER = 6;
    localparam int unsigned ST_TIMEOUT = 7;
    // Register map.
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_STATE = 4'h4;
    localparam logic [3:0] REG_PULLUP = 4'h8;
    // Only the timeout and reset-instruction flags read 1 after power-on; all others read 0.
    localparam logic [ST_W-1:0] STATUS_POR_VALUE = 8'h84;
    typedef enum logic [1:0] {RSSQ_HOLD, RSSQ_TIMER, RSSQ_PIN_WAIT, RSSQ_RUN} rssq_state_t;
endpackage : rssq_pkg

// File: rssq_glitch_filter.sv
`timescale 1ns/10ps
// Passes a level only after it has held steady for the full filter length.
module rssq_glitch_filter #(
    parameter int unsigned LEN = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic din,
    output logic dout
);
    logic [$clog2(LEN+1)-1:0] cnt_q;
    logic dout_q;

    // A level that differs from the output must persist LEN cycles to pass.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            dout_q <= 1'b1;
        end else if (din == dout_q) begin
            cnt_q <= '0;
        end else if (cnt_q == ($clog2(LEN+1))'(LEN - 1)) begin
            cnt_q <= '0;
            dout_q <= din;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign dout = dout_q;
endmodule // rssq_glitch_filter

// File: rssq_props.sv
`timescale 1ns/10ps
// Watches the sequencer ports for slips in reset combining and pin handling.
module rssq_props #(
    parameter int unsigned PUT_COUNT = 20,
    parameter int unsigned FILTER_LEN = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cfg_lp_brownout_enable,
    input wire logic cfg_external_reset_pin_enable,
    input wire logic cfg_low_voltage_programming_enable,
    input wire logic cfg_stack_reset_enable,
    input wire logic brownout_low,
    input wire logic lp_brownout_low,
    input wire logic external_reset_pin_in,
    input wire logic watchdog_overflow,
    input wire logic watchdog_window_violation,
    input wire logic reset_instruction,
    input wire logic stack_underflow,
    input wire logic programming_mode,
    input wire logic device_reset_n,
    input wire logic external_reset_pin_oe_n,
    input wire logic pin_pullup_en
);
    logic pin_func;
    // Either configuration bit turns the pin into a reset input.
    assign pin_func = cfg_external_reset_pin_enable | cfg_low_voltage_programming_enable;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    AST_PIN_NEVER_DRIVEN: assert property (external_reset_pin_oe_n)
        else $error("reset pin driven");
    AST_PULLUP_WITH_PIN: assert property (pin_func && $past(pin_func) |-> pin_pullup_en)
        else $error("pull-up off");
    AST_PIN_HOLDS: assert property ((pin_func && !external_reset_pin_in) [*8] ##1
        (pin_func && !external_reset_pin_in) [*4] |-> !device_reset_n) else $error("low pin ignored");
    AST_GLITCH_IGNORED: assert property (device_reset_n && pin_func && $rose(external_reset_pin_in)
        && $past(external_reset_pin_in, 4) && !brownout_low |=> device_reset_n [*8]) else $error("glitch reset");
    AST_BROWNOUT_HOLDS: assert property ((brownout_low || (lp_brownout_low && cfg_lp_brownout_enable))
        [*4] |-> !device_reset_n) else $error("brown-out ignored");
    AST_PULSE_RESETS: assert property (watchdog_overflow || watchdog_window_violation
        || reset_instruction |-> ##[1:3] !device_reset_n) else $error("pulse ignored");
    AST_STACK_GATED: assert property (stack_underflow && !cfg_stack_reset_enable && device_reset_n
        |=> device_reset_n) else $error("stack reset while off");
    AST_LATE_RELEASE: assert property ($rose(device_reset_n) && pin_func
        |-> $past(external_reset_pin_in, 10)) else $error("early start");
endmodule // rssq_props

bind rssq_sequencer rssq_props #(.PUT_COUNT(PUT_COUNT), .FILTER_LEN(FILTER_LEN)) rssq_props_inst (.*);

// File: rssq_switch_model.sv
`timescale 1ns/10ps
// Push-button on the reset pin, with the pin's pull-up behind it.
module rssq_switch_model (
    input wire logic clk_sys,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic pin_level
);
    logic pressed = 1'b0;
    // A released pin rises through the pull-up unless the device drives it.
    assign pin_level = pressed ? 1'b0 : (pin_oe_n ? 1'b1 : pin_out);
    // Holds the pin low for a number of clock cycles.
    task automatic push(input int n);
        @(posedge clk_sys);
        pressed <= 1'b1;
        repeat (n) @(posedge clk_sys);
        pressed <= 1'b0;
    endtask
endmodule // rssq_switch_model

// File: test_reset_source_and_startup_sequencer.sv
`timescale 1ns/10ps
// Fires each reset source and judges reset timing and cause flags.
module test_reset_source_and_startup_sequencer;
    import rssq_pkg::*;
    localparam int PUT = 20;
    logic clk_sys = 1'b0, resetn = 1'b0, cfg_lp_brownout_enable = 1'b0;
    logic cfg_external_reset_pin_enable = 1'b1, cfg_low_voltage_programming_enable = 1'b0;
    logic cfg_stack_reset_enable = 1'b0, cfg_power_up_timer_enable_n = 1'b0;
    logic [4:0] pulses = 5'h00;
    logic [2:0] levels = 3'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, watchdog_overflow, watchdog_window_violation, reset_instruction;
    logic stack_overflow, stack_underflow, brownout_low, lp_brownout_low, programming_mode;
    logic [7:0] reg_rdata;
    logic device_reset_n, run_enable, external_reset_pin_in, external_reset_pin_out;
    logic external_reset_pin_oe_n, pin_pullup_en, gpio_in;
    int n_fail = 0, n_tests = 0;
    // Source vectors fan out to the single-bit inputs.
    assign {watchdog_overflow, watchdog_window_violation, reset_instruction, stack_overflow, stack_underflow} = pulses;
    assign {brownout_low, lp_brownout_low, programming_mode} = levels;
    // The clock turns over every half period.
    always #5 clk_sys = ~clk_sys;
    rssq_sequencer #(.PUT_COUNT(PUT)) rssq_sequencer_inst (.*);
    rssq_switch_model rssq_switch_model_inst (.clk_sys(clk_sys), .pin_out(external_reset_pin_out),
        .pin_oe_n(external_reset_pin_oe_n), .pin_level(external_reset_pin_in));
    // Compares a seen value with the expected one.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Writes one register in one strobe cycle.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Reads one register and checks the data in the following cycle.
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Counts cycles until the device leaves reset and checks the count.
    task automatic run_within(input int lo, input int hi);
        int n = 0;
        while (device_reset_n !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        chk(n >= lo && n <= hi, 1'b1);
    endtask
    // Pin held past the timer, then a short glitch while running.
    task automatic t_startup();
        fork
            rssq_switch_model_inst.push(PUT + 40);
            repeat (12) @(posedge clk_sys);
        join_any
        resetn <= 1'b1;
        wait fork;
        run_within(10, 24);
        chk(run_enable, 1'b1);
        chk({external_reset_pin_out, external_reset_pin_oe_n}, 8'h03);
        rd(REG_STATUS, STATUS_POR_VALUE);
        rd(REG_STATE, 8'h07);
        rd(4'h2, 8'h00);
        rssq_switch_model_inst.push(3);
        repeat (20) @(posedge clk_sys);
        chk(device_reset_n, 1'b1);
    endtask
    // With the pin function off, a low pin is plain input.
    task automatic t_pin_off();
        cfg_external_reset_pin_enable <= 1'b0;
        wr(REG_PULLUP, 8'h01);
        fork
            rssq_switch_model_inst.push(12);
            repeat (10) @(posedge clk_sys);
        join_any
        chk({pin_pullup_en, gpio_in, device_reset_n}, 8'h05);
        wait fork;
        wr(REG_PULLUP, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk(pin_pullup_en, 1'b0);
        // Let the filter settle high so re-enabling the pin does not reset the device.
        repeat (12) @(posedge clk_sys);
        cfg_external_reset_pin_enable <= 1'b1;
    endtask
    // Pulsed sources: reset (none for stack underflow with its reset off) and the matching cause flag.
    task automatic t_sources();
        logic [7:0] e [5] = '{8'h1f, 8'h8f, 8'h9b, 8'hdf, 8'hbf};
        for (int i = 0; i < 5; i++) begin
            cfg_stack_reset_enable <= (i == 3);
            wr(REG_STATUS, 8'h9f);
            pulses <= 5'h10 >> i;
            @(posedge clk_sys);
            pulses <= 5'h00;
            repeat (3) @(posedge clk_sys);
            chk(device_reset_n, i == 4);
            run_within(0, 16);
            rd(REG_STATUS, e[i]);
        end
    endtask
    // Held sources: brown-out, low-power brown-out and programming mode rerun the timer.
    task automatic t_levels();
        logic [7:0] e [3] = '{8'h9e, 8'h9e, 8'h9d};
        levels <= 3'b010;
        repeat (10) @(posedge clk_sys);
        chk(device_reset_n, 1'b1);
        cfg_lp_brownout_enable <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(REG_STATUS, 8'h9f);
            levels <= 3'b100 >> i;
            repeat (30) @(posedge clk_sys);
            chk(device_reset_n, 1'b0);
            levels <= 3'b000;
            run_within(PUT + 10, PUT + 18);
            rd(REG_STATUS, e[i]);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        t_startup();
        t_pin_off();
        t_sources();
        t_levels();
        results();
    end
    // Watchdog cuts a hang short.
    initial begin
        #100us;
        n_fail++;
        results();
    end
endmodule // test_reset_source_and_startup_sequencer
